//--- rtl/arxcdr_pkg.sv
package arxcdr_pkg;
  // ************************************************************
  // sampling constants
  // ************************************************************
  localparam int unsigned ARXCDR_OVS_NORMAL = 16;
  localparam int unsigned ARXCDR_OVS_DOUBLE = 8;
  // first of three voting samples (middle is +1, last is +2)
  localparam logic [3:0] ARXCDR_VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] ARXCDR_VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] ARXCDR_SAMPLE_IDLE = 4'h0;
  localparam logic [3:0] ARXCDR_SAMPLE_FIRST = 4'h1;
  localparam int unsigned ARXCDR_DIV_W = 12;
  localparam logic [11:0] ARXCDR_DIV_RESET = 12'h000;
  localparam logic [3:0] ARXCDR_BITS_MIN = 4'h5;
  localparam logic [3:0] ARXCDR_BITS_MAX = 4'hA;
  localparam logic [3:0] ARXCDR_BITS_RESET = 4'h8;
  localparam int unsigned ARXCDR_FIFO_DEPTH = 16;
  localparam int unsigned ARXCDR_DATA_W = 10;

  // receiver phases, gray along idle -> start -> data -> stop
  typedef enum logic [1:0] {
    ARXCDR_ST_IDLE = 2'b00,
    ARXCDR_ST_START = 2'b01,
    ARXCDR_ST_DATA = 2'b11,
    ARXCDR_ST_STOP = 2'b10
  } arxcdr_state_t;

  // one received frame
  typedef struct packed {
    logic [ARXCDR_DATA_W-1:0] bits;
    logic [3:0] nbits;
    logic frame_error;
  } arxcdr_frame_t;
  localparam int unsigned ARXCDR_FRAME_W = $bits(arxcdr_frame_t);
endpackage : arxcdr_pkg

//--- rtl/arxcdr_fifo.sv
`timescale 1ns/100ps
module arxcdr_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [WIDTH-1:0] out_q;
  logic out_v_q;
  wire logic full_w = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire logic empty_w = (wr_q == rd_q);
  wire logic push_w = in_valid_i && !full_w;
  // output register refills when empty or consumed
  wire logic load_w = !empty_w && (!out_v_q || out_ready_i);

  assign in_ready_o = !full_w;
  assign out_data_o = out_q;
  assign out_valid_o = out_v_q;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      out_q <= '0;
      out_v_q <= 1'b0;
    end else begin
      if (push_w) wr_q <= wr_q + 1'b1;
      if (load_w) begin
        out_q <= mem_q[rd_q[AW-1:0]];
        rd_q <= rd_q + 1'b1;
        out_v_q <= 1'b1;
      end else if (out_ready_i) begin
        out_v_q <= 1'b0;
      end
    end
  end
endmodule : arxcdr_fifo

//--- rtl/arxcdr_rx.sv
// What this block does
// R1: line sampled at 16x baud normally, 8x in double speed.
// R2: double_speed_select high picks 8x oversampling, else 16x.
// R3: idle line keeps sample counter at zero, waiting.
// R4: high-to-low edge starts detection; first low sample is sample one.
// R5: start judged on samples 8,9,10 normal, 4,5,6 double speed.
// R6: two or more high check samples reject start as noise.
// R7: valid start realigns bit timing; repeats each frame.
// R8: sixteen or eight sample states per bit, numbered by state.
// R9: bit value is majority of three centre samples.
// R10: recover bits through first stop bit only; further stops ignored.
// R11: first stop voted; zero sets frame error.
// R12: next start edge accepted right after last stop vote sample.
// R13: frame length of data plus parity from five to ten bits.
// R14: remote transmitter rate within accepted ratio band.
// R15: baud divisor keeps own rate error within recommended limit.
// R16: frame error zero when stop read one, one when zero.
// R17: sampling tick from baud divider, one per oversample period.
// R18: assembled bits and stop status handed over in one cycle.
`timescale 1ns/100ps
module arxcdr_rx
  import arxcdr_pkg::*;
#(
  parameter int unsigned DIV_W = ARXCDR_DIV_W,
  parameter int unsigned FIFO_DEPTH = ARXCDR_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_receive_line_i,
  input wire logic double_speed_select_i,
  input wire logic [DIV_W-1:0] baud_divisor_value_i,
  input wire logic [3:0] frame_bits_i,
  output logic [ARXCDR_DATA_W-1:0] rx_bits_o,
  output logic [3:0] rx_nbits_o,
  output logic frame_error_flag_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic frame_dropped_o,
  output logic busy_o
);
  // ************************************************************
  // baud divider
  // ************************************************************
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  // R17 divider tick
  wire logic tick_w = (div_q == '0);
  // R15 divisor software set
  assign div_d = tick_w ? baud_divisor_value_i : div_q - 1'b1;

  // reload when reaching zero: period is divisor+1 clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) div_q <= DIV_W'(ARXCDR_DIV_RESET);
    else div_q <= div_d;
  end

  // ************************************************************
  // mode selection
  // ************************************************************
  logic mode_q;
  // samples per bit, captured together with mode_q
  logic [4:0] ovs_q;
  // R2 speed select
  // R1 oversampling rate
  wire logic [4:0] ovs_w = double_speed_select_i ? 5'(ARXCDR_OVS_DOUBLE) : 5'(ARXCDR_OVS_NORMAL);
  // R5 vote positions
  wire logic [3:0] vfirst_w = mode_q ? ARXCDR_VOTE_FIRST_DOUBLE : ARXCDR_VOTE_FIRST_NORMAL;
  wire logic [3:0] vlast_w = vfirst_w + 4'h2;
  // R8 last state of a bit
  wire logic [3:0] last_sample_w = 4'(ovs_q - 5'h01);
  // R13 length clamp
  wire logic [3:0] len_w = (frame_bits_i < ARXCDR_BITS_MIN) ? ARXCDR_BITS_MIN :
                           (frame_bits_i > ARXCDR_BITS_MAX) ? ARXCDR_BITS_MAX : frame_bits_i;

  // ************************************************************
  // recovery state
  // ************************************************************
  arxcdr_state_t state_q;
  arxcdr_state_t state_d;
  logic [3:0] samp_q;
  logic [3:0] samp_d;
  logic [1:0] votes_q;
  logic [1:0] votes_d;
  logic [3:0] bitn_q;
  logic [3:0] bitn_d;
  logic [3:0] len_q;
  logic [ARXCDR_DATA_W-1:0] shift_q;
  logic [ARXCDR_DATA_W-1:0] shift_d;
  logic prev_q;
  logic push_d;
  logic ferr_d;

  wire logic rx_w = serial_receive_line_i;
  // R4 falling edge
  wire logic fall_w = prev_q && !rx_w;
  wire logic in_vote_w = (samp_q >= vfirst_w) && (samp_q <= vlast_w);
  wire logic [1:0] votes_now_w = votes_q + {1'b0, (in_vote_w && rx_w)};
  // R9 majority vote
  wire logic bit_w = votes_now_w[1];
  wire logic end_vote_w = (samp_q == vlast_w);
  wire logic end_bit_w = (samp_q == last_sample_w);
  // stored frame laid out lsb first, right aligned
  wire logic [ARXCDR_DATA_W-1:0] shifted_w = {bit_w, shift_q[ARXCDR_DATA_W-1:1]};
  wire logic [ARXCDR_DATA_W-1:0] aligned_w = shift_q >> (4'(ARXCDR_DATA_W) - len_q);

  // ************************************************************
  // next-state decode
  // ************************************************************
  always_comb begin
    state_d = state_q;
    samp_d = samp_q;
    votes_d = votes_q;
    bitn_d = bitn_q;
    shift_d = shift_q;
    push_d = 1'b0;
    ferr_d = 1'b0;
    if (tick_w) begin
      case (state_q)
        ARXCDR_ST_IDLE: begin
          // R3 idle counter zero
          samp_d = ARXCDR_SAMPLE_IDLE;
          votes_d = 2'h0;
          if (fall_w) begin
            // R4 first low sample
            // this tick is sample one, so the next tick is sample two
            samp_d = ARXCDR_SAMPLE_FIRST + 4'h1;
            state_d = ARXCDR_ST_START;
          end
        end
        ARXCDR_ST_START: begin
          samp_d = samp_q + 4'h1;
          if (in_vote_w) votes_d = votes_now_w;
          if (end_vote_w) begin
            if (bit_w) begin
              // R6 reject noise
              state_d = ARXCDR_ST_IDLE;
              samp_d = ARXCDR_SAMPLE_IDLE;
            end
          end
          if (end_bit_w) begin
            // R7 realign on start
            state_d = ARXCDR_ST_DATA;
            samp_d = 4'h0;
            bitn_d = 4'h0;
            votes_d = 2'h0;
          end
        end
        ARXCDR_ST_DATA: begin
          // R8 per-bit sample states
          samp_d = samp_q + 4'h1;
          if (in_vote_w) votes_d = votes_now_w;
          if (end_vote_w) begin
            shift_d = shifted_w;
          end
          if (end_bit_w) begin
            samp_d = 4'h0;
            votes_d = 2'h0;
            bitn_d = bitn_q + 4'h1;
            // R10 stop after frame
            if (bitn_q == len_q - 4'h1) state_d = ARXCDR_ST_STOP;
          end
        end
        ARXCDR_ST_STOP: begin
          samp_d = samp_q + 4'h1;
          if (in_vote_w) votes_d = votes_now_w;
          if (end_vote_w) begin
            // R11 stop voted
            // R18 single-cycle handover
            push_d = 1'b1;
            // R16 flag polarity
            ferr_d = !bit_w;
            // R12 early next start
            state_d = ARXCDR_ST_IDLE;
            samp_d = ARXCDR_SAMPLE_IDLE;
            votes_d = 2'h0;
          end
        end
        default: begin
          state_d = ARXCDR_ST_IDLE;
          samp_d = ARXCDR_SAMPLE_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // prev_q set high after stop vote so a low sample then reads as an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ARXCDR_ST_IDLE;
      samp_q <= ARXCDR_SAMPLE_IDLE;
      votes_q <= 2'h0;
      bitn_q <= 4'h0;
      shift_q <= '0;
      prev_q <= 1'b0;
      mode_q <= 1'b0;
      len_q <= ARXCDR_BITS_RESET;
      ovs_q <= 5'(ARXCDR_OVS_NORMAL);
    end else begin
      state_q <= state_d;
      samp_q <= samp_d;
      votes_q <= votes_d;
      bitn_q <= bitn_d;
      shift_q <= shift_d;
      if (tick_w) prev_q <= push_d ? 1'b1 : rx_w;
      // mode and length latched per frame at start edge
      if (tick_w && state_q == ARXCDR_ST_IDLE) begin
        mode_q <= double_speed_select_i;
        ovs_q <= ovs_w;
        len_q <= len_w;
      end
    end
  end

  // ************************************************************
  // handover buffer
  // ************************************************************
  arxcdr_frame_t in_frame_w;
  arxcdr_frame_t out_frame_w;
  logic fifo_in_ready_w;
  assign in_frame_w.bits = aligned_w;
  assign in_frame_w.nbits = len_q;
  assign in_frame_w.frame_error = ferr_d;
  wire logic push_w = push_d;

  arxcdr_fifo #(
    .WIDTH(ARXCDR_FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(in_frame_w),
    .in_valid_i(push_w),
    .in_ready_o(fifo_in_ready_w),
    .out_data_o(out_frame_w),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // frame lost when buffer full at stop vote
  logic drop_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) drop_q <= 1'b0;
    else drop_q <= push_w && !fifo_in_ready_w;
  end

  assign rx_bits_o = out_frame_w.bits;
  assign rx_nbits_o = out_frame_w.nbits;
  assign frame_error_flag_o = out_frame_w.frame_error;
  assign frame_dropped_o = drop_q;
  assign busy_o = (state_q != ARXCDR_ST_IDLE);
endmodule : arxcdr_rx

//--- sim/arxcdr_props.sv
`timescale 1ns/100ps
module arxcdr_props
  import arxcdr_pkg::*;
#(
  parameter int unsigned DIV_W = ARXCDR_DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_receive_line_i,
  input wire logic double_speed_select_i,
  input wire logic [DIV_W-1:0] baud_divisor_value_i,
  input wire logic [3:0] frame_bits_i,
  input wire logic [ARXCDR_DATA_W-1:0] rx_bits_o,
  input wire logic [3:0] rx_nbits_o,
  input wire logic frame_error_flag_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic frame_dropped_o,
  input wire logic busy_o
);
  // ****************
  // receiver checks
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !rx_valid_o && !busy_o) else $error("not clear");
  a_valid_holds: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o) else $error("valid lost");
  a_frame_stable: assert property (rx_valid_o && !rx_ready_i |=> $stable(rx_bits_o) && $stable(frame_error_flag_o))
    else $error("frame changed");
  a_start_span: assert property ($rose(busy_o) |=> busy_o [*8]) else $error("start too short");
  a_count_range: assert property (rx_valid_o |-> rx_nbits_o >= ARXCDR_BITS_MIN && rx_nbits_o <= ARXCDR_BITS_MAX)
    else $error("bad count");
  a_upper_zero: assert property (rx_valid_o |-> (rx_bits_o >> rx_nbits_o) == '0) else $error("upper bits set");
  a_drop_pulse: assert property (frame_dropped_o |=> !frame_dropped_o) else $error("long drop");
  a_drop_full: assert property (frame_dropped_o |-> $past(rx_valid_o)) else $error("drop not full");
  c_take: cover property (rx_valid_o && rx_ready_i);
  c_ferr: cover property (rx_valid_o && frame_error_flag_o);
  c_drop: cover property (frame_dropped_o);
endmodule : arxcdr_props

bind arxcdr_rx arxcdr_props #(.DIV_W(DIV_W)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .serial_receive_line_i(serial_receive_line_i), .double_speed_select_i(double_speed_select_i),
  .baud_divisor_value_i(baud_divisor_value_i), .frame_bits_i(frame_bits_i), .rx_bits_o(rx_bits_o),
  .rx_nbits_o(rx_nbits_o), .frame_error_flag_o(frame_error_flag_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .frame_dropped_o(frame_dropped_o), .busy_o(busy_o));

//--- sim/arxcdr_tx_model.sv
`timescale 1ns/100ps
module arxcdr_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  // ****************
  // remote sender
  // ****************
  initial line_o = 1'b1;
  // one frame lsb first, bt clocks per bit, stop held stp clocks
  // rate matches receiver
  task automatic send(input logic [9:0] d, input int n, input logic st, input int bt, input int stp);
    line_o = 1'b0;
    repeat (bt) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o = d[i];
      repeat (bt) @(negedge clk_i);
    end
    line_o = st;
    repeat (stp) @(negedge clk_i);
    line_o = 1'b1;
  endtask : send
  // short low spike
  task automatic glitch(input int k);
    line_o = 1'b0;
    repeat (k) @(negedge clk_i);
    line_o = 1'b1;
  endtask : glitch
endmodule : arxcdr_tx_model

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import arxcdr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dbl = 1'b0;
  // divisor 1 gives exact tick of two clocks
  logic [11:0] div = 12'h001;
  logic [3:0] nb = 4'h8;
  // frame length the receiver should use for nb
  logic [3:0] nexp = 4'h8;
  logic rdy = 1'b0;
  logic line;
  logic [9:0] bits;
  logic [3:0] nbits;
  logic fe, vld, drop, busy;
  int fail_count = 0;
  int num_checks = 0;
  int drops = 0;
  // ****************
  // harness
  // ****************
  always #10 clk_i = ~clk_i;
  // count drop pulses
  always @(posedge clk_i) if (drop === 1'b1) drops <= drops + 1;
  // watchdog
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  arxcdr_rx DUT (.clk_i(clk_i), .rst_i(rst_i), .serial_receive_line_i(line), .double_speed_select_i(dbl),
    .baud_divisor_value_i(div), .frame_bits_i(nb), .rx_bits_o(bits), .rx_nbits_o(nbits),
    .frame_error_flag_o(fe), .rx_valid_o(vld), .rx_ready_i(rdy), .frame_dropped_o(drop), .busy_o(busy));
  arxcdr_tx_model u_tx (.clk_i(clk_i), .line_o(line));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [9:0] d, input logic st, input int stp);
    u_tx.send(d, int'(nexp), st, dbl ? 16 : 32, stp);
  endtask : frame
  task automatic get(input logic [9:0] eb, input logic ef);
    int n;
    n = 0;
    while (vld !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(vld), 16'h0001, "valid");
    check(16'(bits), 16'(eb & (10'h3FF >> (4'hA - nexp))), "bits");
    check(16'(nbits), 16'(nexp), "count");
    check(16'(fe), 16'(ef), "stop");
    rdy = 1'b1;
    @(negedge clk_i);
    rdy = 1'b0;
    @(negedge clk_i);
  endtask : get
  task automatic t_modes();
    for (int m = 0; m < 2; m++) begin
      dbl = m[0];
      frame(10'h0A5, 1'b1, dbl ? 16 : 32);
      get(10'h0A5, 1'b0);
    end
    dbl = 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_lengths();
    for (int n = 5; n <= 10; n++) begin
      nb = 4'(n);
      nexp = 4'(n);
      frame(10'h2B6, 1'b1, 32);
      get(10'h2B6, 1'b0);
    end
    // out-of-range settings clamp to the nearest legal length
    nb = 4'h3;
    nexp = 4'h5;
    frame(10'h2B6, 1'b1, 32);
    get(10'h2B6, 1'b0);
    nb = 4'hF;
    nexp = 4'hA;
    frame(10'h1D9, 1'b1, 32);
    get(10'h1D9, 1'b0);
    nb = 4'h8;
    nexp = 4'h8;
    $display("test lengths done");
  endtask : t_lengths
  // low stop, tail rejected as noise
  task automatic t_ferr();
    int n;
    frame(10'h055, 1'b0, 32);
    get(10'h055, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(vld), 16'h0000, "tail frame");
    $display("test ferr done");
  endtask : t_ferr
  task automatic t_noise();
    u_tx.glitch(8);
    repeat (60) @(negedge clk_i);
    check(16'(vld), 16'h0000, "spike frame");
    frame(10'h0C3, 1'b1, 32);
    get(10'h0C3, 1'b0);
    $display("test noise done");
  endtask : t_noise
  // next start right after stop vote
  task automatic t_back();
    frame(10'h011, 1'b1, 22);
    frame(10'h022, 1'b1, 32);
    get(10'h011, 1'b0);
    get(10'h022, 1'b0);
    $display("test back done");
  endtask : t_back
  // fill buffer until a frame drops, then drain
  task automatic t_full();
    for (int i = 0; i < 18; i++) frame(10'(i), 1'b1, 32);
    repeat (4) @(negedge clk_i);
    check(16'(drops), 16'h0001, "drops");
    for (int i = 0; i < 17; i++) get(10'(i), 1'b0);
    check(16'(vld), 16'h0000, "empty");
    $display("test full done");
  endtask : t_full
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(16'(busy), 16'h0000, "idle");
    t_modes();
    t_lengths();
    t_ferr();
    t_noise();
    t_back();
    t_full();
    end_of_test();
  end
endmodule : testbench
